// file: hw/exception_vector_unit.sv
// Exception recognition, prioritisation and vectoring with fault-cause reg
//
// How it works
// - Soft or hard reset pin gives vector 00100.
// - Transfer error in a data bus transaction, machine check, parity give 00200.
// - Data fault sets cause bit 1 on translation miss.
// - Data fault sets cause bit 4 on protection.
// - Cause bit 5: external/reserve word in I/O segment.
// - Cause bit 6 set on store, cleared on load.
// - Cause bit 11: external-control word while disabled.
// - Untranslatable fetch gives instruction fault at 00400.
// - Fetch from direct-store segment gives instruction fault.
// - Key and page bits forbidding read fault fetch.
// - External interrupt 00500 needs enable and pin asserted.
// - Impossible access, FP op in I/O segment: 00600.
// - External, countdown, management interrupts: maskable, precise.
// - Instruction exceptions are synchronous and always precise.
// - Imprecise FP mode still delivers precise exceptions.
// - Maskable async waits for instruction completion.
// - FP enabled, illegal, privileged, trap give 00700.
// - FP instruction while FP unavailable gives 00800.
// - Countdown msb rising with enable gives 00900.
`default_nettype none
`include "exc_defs.svh"
module exception_vector_unit (
	input  wire logic          i_core_clk,
	input  wire logic          i_reset,
	// Avalon-MM slave
	input  wire logic [3:0]    i_avs_address,
	input  wire logic          i_avs_read,
	input  wire logic          i_avs_write,
	input  wire logic [31:0]   i_avs_writedata,
	input  wire logic [3:0]    i_avs_byteenable,
	output logic [31:0]        o_avs_readdata,
	output logic               o_avs_waitrequest,
	// Asynchronous pins from system logic
	input  wire logic          i_soft_reset_in,
	input  wire logic          i_hard_reset_in,
	input  wire logic          i_machine_check_in,
	input  wire logic          i_transfer_error_in,
	input  wire logic          i_ext_int_in,
	input  wire logic          i_system_mgmt_int,
	// Same-clock indications from bus and parity logic
	input  wire logic          i_data_bus_active,
	input  wire logic          i_addr_parity_err,
	input  wire logic          i_data_parity_err,
	// Load/store unit data fault inputs
	input  wire logic          i_dsf_valid,
	input  wire logic          i_dsf_not_found,
	input  wire logic          i_dsf_protect,
	input  wire logic          i_dsf_segment_io_flag,
	input  wire logic          i_dsf_ext_ctl_op,
	input  wire logic          i_dsf_reserve_op,
	input  wire logic          i_dsf_store,
	// Fetch unit inputs
	input  wire logic          i_fetch_valid,
	input  wire logic          i_fetch_no_xlate,
	input  wire logic          i_fetch_direct_store,
	input  wire logic          i_supervisor_key,
	input  wire logic          i_user_key,
	input  wire logic [1:0]    i_page_protect_bits,
	// Execution inputs
	input  wire logic          i_user_state,
	input  wire logic          i_align_fault,
	input  wire logic          i_fp_mem_op,
	input  wire logic          i_operand_io_seg,
	input  wire logic          i_fp_enabled_exc,
	input  wire logic          i_illegal_op,
	input  wire logic          i_priv_op,
	input  wire logic          i_trap_hit,
	input  wire logic          i_fp_instr,
	input  wire logic          i_countdown_msb,
	input  wire logic          i_instr_busy,
	input  wire logic          i_instr_done,
	// Exception delivery
	output logic               o_exc_take,
	output exc_pkg::vector_t   o_exc_vector,
	output exc_pkg::exc_kind_e o_exc_kind,
	output logic               o_exc_sync,
	output logic               o_exc_precise,
	output logic               o_exc_maskable
);
	import exc_pkg::*;

	// --------------------
	// Declarations
	// --------------------
	logic [`EXC_PIN_COUNT-1:0] pins_raw;     // Pin bundle before sync
	logic [`EXC_PIN_COUNT-1:0] pins_sync;    // Pin bundle after sync
	logic [`EXC_PIN_COUNT-1:0] pins_prev_ff; // For rising edge detect
	logic [`EXC_PIN_COUNT-1:0] pins_rise;    // One-cycle rise pulses
	logic [3:0]    ctrl_ff;          // Software control bits
	logic [3:0]    nxt_ctrl;
	logic [31:0]   fault_cause_ff;   // Data access fault cause
	logic [31:0]   nxt_fault_cause;
	logic          rst_pend_ff;      // System reset pending
	logic          mc_pend_ff;       // Machine check pending
	logic          cd_pend_ff;       // Countdown pending
	logic          cd_msb_prev_ff;   // Countdown msb last cycle
	logic          ack_ff;           // Bus answer phase
	logic [31:0]   rdata_ff;         // Registered read data
	logic          take_ff;
	vector_t       vector_ff;
	exc_kind_e     kind_ff;
	logic          sync_ff;
	logic          precise_ff;
	logic          maskable_ff;
	logic          mc_event;         // New machine check cause
	logic          async_en;
	logic          fp_avail;
	logic          ext_acc_en;
	logic          dsf_hit;
	logic          isf_read_blocked;
	logic          isf_hit;
	logic          align_hit;
	logic          prog_hit;
	logic          fpu_hit;
	logic          async_window;     // Maskable async may be taken
	logic          ext_hit;
	logic          cd_hit;
	logic          smi_hit;
	exc_kind_e     sel_kind;         // Winner this cycle
	logic          wr_en;            // Write takes effect this edge
	logic [31:0]   be_mask;          // Byte enables widened to bits

	// --------------------
	// Pin synchronisers
	// --------------------
	assign pins_raw[`EXC_PIN_SOFT_RST] = i_soft_reset_in;
	assign pins_raw[`EXC_PIN_HARD_RST] = i_hard_reset_in;
	assign pins_raw[`EXC_PIN_MACH_CHK] = i_machine_check_in;
	assign pins_raw[`EXC_PIN_XFER_ERR] = i_transfer_error_in;
	assign pins_raw[`EXC_PIN_EXT_INT]  = i_ext_int_in;
	assign pins_raw[`EXC_PIN_SYS_MGMT] = i_system_mgmt_int;

	// One synchroniser per pin lane
	genvar g;
	generate
		for (g = 0; g < `EXC_PIN_COUNT; g = g + 1) begin : g_pin
			pin_sync u_sync (
				.i_core_clk (i_core_clk),
				.i_reset    (i_reset),
				.i_async    (pins_raw[g]),
				.o_sync     (pins_sync[g])
			);
		end
	endgenerate

	// Edge detect works on the second stage only
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			pins_prev_ff <= '0;
		end else begin
			pins_prev_ff <= pins_sync;
		end
	end
	assign pins_rise = pins_sync & ~pins_prev_ff;

	// --------------------
	// Control decode
	// --------------------
	assign async_en   = ctrl_ff[`EXC_CTRL_ASYNC_EN];
	assign fp_avail   = ctrl_ff[`EXC_CTRL_FP_AVAIL];
	assign ext_acc_en = ctrl_ff[`EXC_CTRL_EXT_ACC_EN];

	// --------------------
	// Non-maskable causes
	// --------------------
	// Transfer error counts only inside a data bus transaction
	assign mc_event = pins_rise[`EXC_PIN_MACH_CHK]
		| (pins_rise[`EXC_PIN_XFER_ERR] & i_data_bus_active)
		| i_addr_parity_err | i_data_parity_err;

	// Pending flags: a new cause wins over the clear on take
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			rst_pend_ff <= 1'b0;
			mc_pend_ff  <= 1'b0;
		end else begin
			rst_pend_ff <= (rst_pend_ff & (sel_kind != EXC_SYS_RESET))
				| pins_rise[`EXC_PIN_SOFT_RST]
				| pins_rise[`EXC_PIN_HARD_RST];
			mc_pend_ff <= (mc_pend_ff & (sel_kind != EXC_MACH_CHECK))
				| mc_event;
		end
	end

	// --------------------
	// Instruction-caused causes, held by the pipeline until taken
	// --------------------
	// Ext-control word with access disabled is itself a data fault
	assign dsf_hit = i_dsf_valid
		| (i_dsf_ext_ctl_op & ~ext_acc_en);

	// Read blocked when selected key is 1 and page bits are 00
	assign isf_read_blocked = (i_user_state ? i_user_key : i_supervisor_key)
		& (i_page_protect_bits == 2'b00);
	assign isf_hit = i_fetch_valid & (i_fetch_no_xlate
		| i_fetch_direct_store
		| isf_read_blocked);

	assign align_hit = i_align_fault
		| (i_fp_mem_op & i_operand_io_seg);

	// Imprecise FP mode bit is ignored: FP faults always come here
	assign prog_hit = i_fp_enabled_exc
		| i_illegal_op
		| (i_priv_op & i_user_state)
		| i_trap_hit;

	assign fpu_hit = i_fp_instr & ~fp_avail;

	// --------------------
	// Maskable asynchronous causes
	// --------------------
	// Idle pipeline takes at once, else wait for completion
	assign async_window = ~i_instr_busy | i_instr_done;

	assign ext_hit = async_en & pins_sync[`EXC_PIN_EXT_INT];
	assign cd_hit  = async_en & cd_pend_ff;
	assign smi_hit = async_en & pins_sync[`EXC_PIN_SYS_MGMT];

	// Countdown msb 0->1 latches a request until serviced
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			cd_msb_prev_ff <= 1'b0;
			cd_pend_ff     <= 1'b0;
		end else begin
			cd_msb_prev_ff <= i_countdown_msb;
			cd_pend_ff <= (cd_pend_ff & (sel_kind != EXC_COUNTDOWN))
				| (i_countdown_msb & ~cd_msb_prev_ff);
		end
	end

	// --------------------
	// Priority selection
	// --------------------
	// At most one winner; reset and machine check first, then synchronous faults, then maskable async ones
	always_comb begin
		if (rst_pend_ff) begin
			sel_kind = EXC_SYS_RESET;
		end else if (mc_pend_ff) begin
			sel_kind = EXC_MACH_CHECK;
		end else if (isf_hit) begin
			sel_kind = EXC_INSTR_FAULT;
		end else if (dsf_hit) begin
			sel_kind = EXC_DATA_FAULT;
		end else if (align_hit) begin
			sel_kind = EXC_ALIGN;
		end else if (prog_hit) begin
			sel_kind = EXC_PROGRAM;
		end else if (fpu_hit) begin
			sel_kind = EXC_FP_UNAVAIL;
		end else if (async_window & ext_hit) begin
			sel_kind = EXC_EXT_INT;
		end else if (async_window & cd_hit) begin
			sel_kind = EXC_COUNTDOWN;
		end else if (async_window & smi_hit) begin
			sel_kind = EXC_SYS_MGMT;
		end else begin
			sel_kind = EXC_NONE;
		end
	end

	// --------------------
	// Delivery registers
	// --------------------
	// Vector and class are registered; take is high after every cycle with a winner
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			take_ff     <= 1'b0;
			vector_ff   <= `EXC_VEC_NONE;
			kind_ff     <= EXC_NONE;
			sync_ff     <= 1'b0;
			precise_ff  <= 1'b0;
			maskable_ff <= 1'b0;
		end else begin
			take_ff <= (sel_kind != EXC_NONE);
			if (sel_kind != EXC_NONE) begin
				kind_ff <= sel_kind;
			end
			case (sel_kind)
				EXC_SYS_RESET: begin
					vector_ff   <= `EXC_VEC_SYS_RESET;
					sync_ff     <= 1'b0;
					precise_ff  <= 1'b0;
					maskable_ff <= 1'b0;
				end
				EXC_MACH_CHECK: begin
					vector_ff   <= `EXC_VEC_MACH_CHECK;
					sync_ff     <= 1'b0;
					precise_ff  <= 1'b0;
					maskable_ff <= 1'b0;
				end
				EXC_INSTR_FAULT, EXC_DATA_FAULT, EXC_ALIGN,
				EXC_PROGRAM, EXC_FP_UNAVAIL: begin
					sync_ff     <= 1'b1;
					precise_ff  <= 1'b1;
					maskable_ff <= 1'b0;
					case (sel_kind)
						EXC_INSTR_FAULT: vector_ff <= `EXC_VEC_INSTR_FAULT;
						EXC_DATA_FAULT:  vector_ff <= `EXC_VEC_DATA_FAULT;
						EXC_ALIGN:       vector_ff <= `EXC_VEC_ALIGN;
						EXC_PROGRAM:     vector_ff <= `EXC_VEC_PROGRAM;
						default:         vector_ff <= `EXC_VEC_FP_UNAVAIL;
					endcase
				end
				EXC_EXT_INT, EXC_COUNTDOWN, EXC_SYS_MGMT: begin
					sync_ff     <= 1'b0;
					precise_ff  <= 1'b1;
					maskable_ff <= 1'b1;
					case (sel_kind)
						EXC_EXT_INT:   vector_ff <= `EXC_VEC_EXT_INT;
						EXC_COUNTDOWN: vector_ff <= `EXC_VEC_COUNTDOWN;
						default:       vector_ff <= `EXC_VEC_SYS_MGMT;
					endcase
				end
				default: begin
					// Nothing taken: keep last vector and class visible
					vector_ff <= vector_ff;
				end
			endcase
		end
	end

	assign o_exc_take     = take_ff;
	assign o_exc_vector   = vector_ff;
	assign o_exc_kind     = kind_ff;
	assign o_exc_sync     = sync_ff;
	assign o_exc_precise  = precise_ff;
	assign o_exc_maskable = maskable_ff;

	// --------------------
	// Avalon-MM slave timing
	// --------------------
	// One wait state: data is looked up, then the access completes
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;
	assign wr_en = i_avs_write & ack_ff;

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (i_avs_read | i_avs_write) & ~ack_ff;
		end
	end

	// Byte enables widened to a bit mask
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_be
			assign be_mask[g*8 +: 8] = {8{i_avs_byteenable[g]}};
		end
	endgenerate

	// Read data captured in the wait cycle; unmapped reads give zero
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			rdata_ff <= '0;
		end else if (i_avs_read & ~ack_ff) begin
			case (i_avs_address)
				`EXC_OFS_CTRL:        rdata_ff <= {28'h0, ctrl_ff};
				`EXC_OFS_STATUS:      rdata_ff <= {6'h0,
					sync_ff, precise_ff,
					pins_sync[`EXC_PIN_EXT_INT],
					mc_pend_ff, rst_pend_ff, cd_pend_ff,
					vector_ff};
				`EXC_OFS_FAULT_CAUSE: rdata_ff <= fault_cause_ff;
				default:              rdata_ff <= 32'h0000_0000;
			endcase
		end
	end
	assign o_avs_readdata = rdata_ff;

	// --------------------
	// Control register
	// --------------------
	// Any exception taken drops the async enable, like supervisor
	// entry does; this also stops a level interrupt re-firing.
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_en & (i_avs_address == `EXC_OFS_CTRL)
			& i_avs_byteenable[0]) begin
			nxt_ctrl = i_avs_writedata[3:0];
		end
		if (sel_kind != EXC_NONE) begin
			nxt_ctrl[`EXC_CTRL_ASYNC_EN] = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			ctrl_ff <= `EXC_CTRL_RESET;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// --------------------
	// Data access fault cause register
	// --------------------
	// Hardware load on a taken data fault wins over a software write
	always_comb begin
		nxt_fault_cause = fault_cause_ff;
		if (wr_en & (i_avs_address == `EXC_OFS_FAULT_CAUSE)) begin
			nxt_fault_cause = (fault_cause_ff & ~be_mask)
				| (i_avs_writedata & be_mask);
		end
		if (sel_kind == EXC_DATA_FAULT) begin
			nxt_fault_cause = 32'h0000_0000;
			nxt_fault_cause[`EXC_FC_NOT_FOUND] =
				i_dsf_not_found;
			nxt_fault_cause[`EXC_FC_PROTECT] =
				i_dsf_protect;
			nxt_fault_cause[`EXC_FC_IO_SEGMENT] = i_dsf_segment_io_flag
				& (i_dsf_ext_ctl_op | i_dsf_reserve_op);
			nxt_fault_cause[`EXC_FC_STORE] = i_dsf_store;
			nxt_fault_cause[`EXC_FC_EXT_DISABLED] =
				i_dsf_ext_ctl_op & ~ext_acc_en;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			fault_cause_ff <= `EXC_FC_RESET;
		end else begin
			fault_cause_ff <= nxt_fault_cause;
		end
	end
endmodule
`default_nettype wire

// file: hw/exc_defs.svh
// Constants for the exception vector unit: offsets, vectors, fields, resets
`ifndef EXC_DEFS_SVH
`define EXC_DEFS_SVH

// --------------------
// Register byte offsets on the Avalon-MM slave
// --------------------
`define EXC_OFS_CTRL        4'h0
`define EXC_OFS_STATUS      4'h4
`define EXC_OFS_FAULT_CAUSE 4'h8

// --------------------
// Vector offsets, 20 bits wide
// --------------------
`define EXC_VEC_NONE        20'h00000
`define EXC_VEC_SYS_RESET   20'h00100
`define EXC_VEC_MACH_CHECK  20'h00200
`define EXC_VEC_DATA_FAULT  20'h00300
`define EXC_VEC_INSTR_FAULT 20'h00400
`define EXC_VEC_EXT_INT     20'h00500
`define EXC_VEC_ALIGN       20'h00600
`define EXC_VEC_PROGRAM     20'h00700
`define EXC_VEC_FP_UNAVAIL  20'h00800
`define EXC_VEC_COUNTDOWN   20'h00900
`define EXC_VEC_SYS_MGMT    20'h01400

// --------------------
// Control register fields
// --------------------
`define EXC_CTRL_ASYNC_EN   0
`define EXC_CTRL_FP_AVAIL   1
`define EXC_CTRL_FP_IMPREC  2
`define EXC_CTRL_EXT_ACC_EN 3
`define EXC_CTRL_RESET      4'h0

// --------------------
// Status register fields
// --------------------
`define EXC_ST_VEC_MSB      19
`define EXC_ST_CD_PEND      20
`define EXC_ST_RST_PEND     21
`define EXC_ST_MC_PEND      22
`define EXC_ST_EXT_INT      23
`define EXC_ST_PRECISE      24
`define EXC_ST_SYNC         25

// --------------------
// Fault cause register fields
// --------------------
`define EXC_FC_NOT_FOUND    1
`define EXC_FC_PROTECT      4
`define EXC_FC_IO_SEGMENT   5
`define EXC_FC_STORE        6
`define EXC_FC_EXT_DISABLED 11
`define EXC_FC_RESET        32'h0000_0000

// --------------------
// Pin synchroniser lanes
// --------------------
`define EXC_PIN_SOFT_RST    0
`define EXC_PIN_HARD_RST    1
`define EXC_PIN_MACH_CHK    2
`define EXC_PIN_XFER_ERR    3
`define EXC_PIN_EXT_INT     4
`define EXC_PIN_SYS_MGMT    5
`define EXC_PIN_COUNT       6

`endif

// file: hw/exc_pkg.sv
// Types shared by the exception vector unit
`default_nettype none
package exc_pkg;
	// Exception kind, one-hot
	typedef enum logic [9:0] {
		EXC_NONE        = 10'h000,
		EXC_SYS_RESET   = 10'h001,
		EXC_MACH_CHECK  = 10'h002,
		EXC_DATA_FAULT  = 10'h004,
		EXC_INSTR_FAULT = 10'h008,
		EXC_EXT_INT     = 10'h010,
		EXC_ALIGN       = 10'h020,
		EXC_PROGRAM     = 10'h040,
		EXC_FP_UNAVAIL  = 10'h080,
		EXC_COUNTDOWN   = 10'h100,
		EXC_SYS_MGMT    = 10'h200
	} exc_kind_e;
	typedef logic [19:0] vector_t;
endpackage
`default_nettype wire

// file: hw/pin_sync.sv
// Two-stage synchroniser for one asynchronous pin
`default_nettype none
module pin_sync (
	input  wire logic i_core_clk,
	input  wire logic i_reset,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_ff; // First stage, read only by the second
	logic sync_ff; // Second stage, safe for logic

	// --------------------
	// Two flops in series
	// --------------------
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule
`default_nettype wire

// file: tb/exc_unit_checker.sv
// Port-level assertions for the exception vector unit
`default_nettype none
`include "exc_defs.svh"
module exc_unit_checker (
	input wire logic               i_core_clk,
	input wire logic               i_reset,
	input wire logic               i_soft_reset_in,
	input wire logic               i_hard_reset_in,
	input wire logic               i_machine_check_in,
	input wire logic               i_transfer_error_in,
	input wire logic               i_addr_parity_err,
	input wire logic               i_data_parity_err,
	input wire logic               i_dsf_valid,
	input wire logic               i_fetch_valid,
	input wire logic               i_instr_busy,
	input wire logic               i_instr_done,
	input wire logic               o_exc_take,
	input wire exc_pkg::vector_t   o_exc_vector,
	input wire exc_pkg::exc_kind_e o_exc_kind,
	input wire logic               o_exc_sync,
	input wire logic               o_exc_precise,
	input wire logic               o_exc_maskable
);
	import exc_pkg::*;
	// --------------------
	// Clocking and shared sequences
	// --------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);
	// No reset, machine check or parity cause that outranks a data fault is on its way
	sequence quiet_s;
		!(i_soft_reset_in | i_hard_reset_in | i_machine_check_in |
		  i_transfer_error_in | i_addr_parity_err | i_data_parity_err);
	endsequence
	// Five quiet cycles, so the pin synchronisers hold no rise
	sequence lone_dsf_s;
		quiet_s [*5] ##0 (i_dsf_valid & !i_fetch_valid);
	endsequence
	// Vector and {sync, precise, maskable} of one taken kind
	property vec_p(exc_kind_e k, vector_t v, logic [2:0] c);
		o_exc_take && o_exc_kind == k |-> o_exc_vector == v &&
		{o_exc_sync, o_exc_precise, o_exc_maskable} == c;
	endproperty
	// --------------------
	// Assertions
	// --------------------
	a_reset_vec:
	assert property (vec_p(EXC_SYS_RESET, `EXC_VEC_SYS_RESET, 3'b000))
		else $error("bad reset vector");
	a_mcheck_vec:
	assert property (vec_p(EXC_MACH_CHECK, `EXC_VEC_MACH_CHECK, 3'b000))
		else $error("bad machine check vector");
	a_dfault_vec:
	assert property (vec_p(EXC_DATA_FAULT, `EXC_VEC_DATA_FAULT, 3'b110))
		else $error("bad data fault vector");
	a_ifault_vec:
	assert property (vec_p(EXC_INSTR_FAULT, `EXC_VEC_INSTR_FAULT, 3'b110))
		else $error("bad fetch fault vector");
	a_ext_vec:
	assert property (vec_p(EXC_EXT_INT, `EXC_VEC_EXT_INT, 3'b011))
		else $error("bad external vector");
	a_align_vec:
	assert property (vec_p(EXC_ALIGN, `EXC_VEC_ALIGN, 3'b110))
		else $error("bad alignment vector");
	a_prog_vec:
	assert property (vec_p(EXC_PROGRAM, `EXC_VEC_PROGRAM, 3'b110))
		else $error("bad program vector");
	a_fpu_vec:
	assert property (vec_p(EXC_FP_UNAVAIL, `EXC_VEC_FP_UNAVAIL, 3'b110))
		else $error("bad fp unavailable vector");
	a_cdown_vec:
	assert property (vec_p(EXC_COUNTDOWN, `EXC_VEC_COUNTDOWN, 3'b011))
		else $error("bad countdown vector");
	a_dfault_next:
	assert property (lone_dsf_s |=> o_exc_take && o_exc_kind == EXC_DATA_FAULT)
		else $error("data fault not taken next cycle");
	a_async_defer:
	assert property (o_exc_take && o_exc_maskable |->
		$past(!i_instr_busy || i_instr_done)) else $error("async not deferred");
endmodule
bind exception_vector_unit exc_unit_checker u_exc_unit_checker (
	.i_core_clk, .i_reset, .i_soft_reset_in, .i_hard_reset_in,
	.i_machine_check_in, .i_transfer_error_in, .i_addr_parity_err,
	.i_data_parity_err, .i_dsf_valid, .i_fetch_valid, .i_instr_busy,
	.i_instr_done, .o_exc_take, .o_exc_vector, .o_exc_kind, .o_exc_sync,
	.o_exc_precise, .o_exc_maskable);
`default_nettype wire

// file: tb/sys_pin_model.sv
// System logic model that drives the exception request pins
`default_nettype none
module sys_pin_model (
	input  wire logic       i_core_clk,
	input  wire logic       i_reset,
	input  wire logic [5:0] i_req,
	output logic      [5:0] o_pins
);
	// Pins follow requests one edge later; released pins fall to idle low
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_pins <= 6'h00;
		end else begin
			o_pins <= i_req;
		end
	end
endmodule
`default_nettype wire

// file: tb/exception_vector_unit_tb.sv
// Self-checking bench for the exception vector unit
`default_nettype none
`include "exc_defs.svh"
module exception_vector_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import exc_pkg::*;
	// --------------------
	// Stimulus, outputs and score
	// --------------------
	logic        clk, rst, rd, wr, busy, done, bus_act, cd_msb;
	logic        wreq, take, s_o, p_o, m_o;
	logic [3:0]  adr;
	logic [31:0] wd, rdata, rs;
	logic [24:0] sc;     // Same-clock fault lines, one bit each but two for page bits
	logic [5:0]  req, pins;
	vector_t     vec;
	exc_kind_e   kind;
	logic [32:0] eq[$];  // Expected {vector, kind, class}
	logic [32:0] ifx, alx, pgx, mcx, rsx; // Common expectations
	logic [31:0] rq[$];  // Expected read data
	int          bad_count, samples_checked;
	exception_vector_unit u_exception_vector_unit (
		.i_core_clk(clk), .i_reset(rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_soft_reset_in(pins[0]),
		.i_hard_reset_in(pins[1]), .i_machine_check_in(pins[2]),
		.i_transfer_error_in(pins[3]), .i_ext_int_in(pins[4]),
		.i_system_mgmt_int(pins[5]), .i_data_bus_active(bus_act),
		.i_addr_parity_err(sc[23]), .i_data_parity_err(sc[24]),
		.i_dsf_valid(sc[0]), .i_dsf_not_found(sc[1]),
		.i_dsf_protect(sc[2]), .i_dsf_segment_io_flag(sc[3]),
		.i_dsf_ext_ctl_op(sc[4]), .i_dsf_reserve_op(sc[5]),
		.i_dsf_store(sc[6]), .i_fetch_valid(sc[7]),
		.i_fetch_no_xlate(sc[8]), .i_fetch_direct_store(sc[9]),
		.i_supervisor_key(sc[10]), .i_user_key(sc[11]),
		.i_page_protect_bits(sc[13:12]), .i_user_state(sc[14]),
		.i_align_fault(sc[15]), .i_fp_mem_op(sc[16]),
		.i_operand_io_seg(sc[17]), .i_fp_enabled_exc(sc[18]),
		.i_illegal_op(sc[19]), .i_priv_op(sc[20]), .i_trap_hit(sc[21]),
		.i_fp_instr(sc[22]), .i_countdown_msb(cd_msb),
		.i_instr_busy(busy), .i_instr_done(done), .o_exc_take(take),
		.o_exc_vector(vec), .o_exc_kind(kind), .o_exc_sync(s_o),
		.o_exc_precise(p_o), .o_exc_maskable(m_o));
	sys_pin_model u_sys_pin_model (.i_core_clk(clk), .i_reset(rst),
		.i_req(req), .o_pins(pins));
	// --------------------
	// Helpers
	// --------------------
	task automatic check(string n, logic [32:0] seen, logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	function automatic logic [31:0] rnd(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Bus cycle: hold the request until waitrequest is seen low
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(logic [3:0] a, logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	function automatic logic [32:0] x(vector_t v, exc_kind_e k, logic [2:0] c);
		return {v, k, c};
	endfunction
	// Long enough for pin synchronisers; every expected take must be in
	task automatic settle;
		repeat (10) @(posedge clk);
		check("pending", 33'(eq.size()), 33'h0);
	endtask
	// One-cycle same-clock cause; kind none means no take may follow
	task automatic one(logic [24:0] m, logic [32:0] e);
		if (e[12:3] != 10'h0) eq.push_back(e);
		@(posedge clk);
		sc <= m;
		@(posedge clk);
		sc <= 25'h0;
		settle();
	endtask
	task automatic pin(logic [5:0] m, logic [32:0] e);
		if (e[12:3] != 10'h0) eq.push_back(e);
		req <= m;
		settle();
		req <= 6'h0;
		repeat (4) @(posedge clk);
	endtask
	// --------------------
	// Clock, monitor and watchdog
	// --------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Each take or read completion is matched with the oldest note
	always @(posedge clk) begin
		if (take === 1'b1 && eq.size() == 0) check("extra take", 33'h1, 33'h0);
		else if (take === 1'b1) check("exc", {vec, kind, s_o, p_o, m_o},
			eq.pop_front());
		if (rd && wreq === 1'b0) check("rdata", {1'b0, rdata},
			{1'b0, rq.pop_front()});
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end
	// --------------------
	// Scenarios
	// --------------------
	initial begin
		{rd, wr, busy, done, bus_act, cd_msb, adr, wd, sc, req} = '0;
		rs = 32'd66;
		ifx = x(`EXC_VEC_INSTR_FAULT, EXC_INSTR_FAULT, 3'b110);
		alx = x(`EXC_VEC_ALIGN, EXC_ALIGN, 3'b110);
		pgx = x(`EXC_VEC_PROGRAM, EXC_PROGRAM, 3'b110);
		mcx = x(`EXC_VEC_MACH_CHECK, EXC_MACH_CHECK, 3'b000);
		rsx = x(`EXC_VEC_SYS_RESET, EXC_SYS_RESET, 3'b000);
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdc(`EXC_OFS_CTRL, 32'h0);
		rdc(`EXC_OFS_FAULT_CAUSE, `EXC_FC_RESET);
		rdc(4'hc, 32'h0);
		rs = rnd(rs);
		bus(1'b1, `EXC_OFS_FAULT_CAUSE, rs);
		rdc(`EXC_OFS_FAULT_CAUSE, rs);
		// Random data faults under both settings of external access
		for (int i = 0; i < 8; i++) begin
			rs = rnd(rs);
			bus(1'b1, `EXC_OFS_CTRL, {28'h0, rs[7], 3'h0});
			one({18'h0, rs[6:1], 1'b1},
				x(`EXC_VEC_DATA_FAULT, EXC_DATA_FAULT, 3'b110));
			rdc(`EXC_OFS_FAULT_CAUSE, {20'h0, rs[4] & !rs[7], 4'h0, rs[6],
				rs[3] & (rs[4] | rs[5]), rs[2], 2'h0, rs[1], 1'b0});
		end
		one(25'h0000180, ifx);
		one(25'h0000280, ifx);
		one(25'h0004880, ifx);
		one(25'h0005880, 33'h0);
		one(25'h0008000, alx);
		one(25'h0030000, alx);
		// Imprecise mode and fp available set
		bus(1'b1, `EXC_OFS_CTRL, 32'h6);
		one(25'h0040000, pgx);
		one(25'h0080000, pgx);
		one(25'h0104000, pgx);
		one(25'h0100000, 33'h0);
		one(25'h0200000, pgx);
		one(25'h0400000, 33'h0);
		bus(1'b1, `EXC_OFS_CTRL, 32'h0);
		one(25'h0400000, x(`EXC_VEC_FP_UNAVAIL, EXC_FP_UNAVAIL, 3'b110));
		one(25'h0000181, ifx);
		one(25'h0800000, mcx);
		one(25'h1000000, mcx);
		// Pins from the system side
		pin(6'h01, rsx);
		pin(6'h02, rsx);
		pin(6'h04, mcx);
		pin(6'h08, 33'h0);
		bus_act <= 1'b1;
		pin(6'h08, mcx);
		bus_act <= 1'b0;
		eq.push_back(rsx);
		pin(6'h06, mcx);
		pin(6'h10, 33'h0);
		// External request held while an instruction is still running
		busy <= 1'b1;
		bus(1'b1, `EXC_OFS_CTRL, 32'h1);
		req <= 6'h10;
		settle();
		eq.push_back(x(`EXC_VEC_EXT_INT, EXC_EXT_INT, 3'b011));
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		busy <= 1'b0;
		req <= 6'h0;
		settle();
		bus(1'b1, `EXC_OFS_CTRL, 32'h1);
		pin(6'h20, x(`EXC_VEC_SYS_MGMT, EXC_SYS_MGMT, 3'b011));
		bus(1'b1, `EXC_OFS_CTRL, 32'h1);
		eq.push_back(x(`EXC_VEC_COUNTDOWN, EXC_COUNTDOWN, 3'b011));
		cd_msb <= 1'b1;
		settle();
		cd_msb <= 1'b0;
		tally_and_finish();
	end
endmodule
`default_nettype wire
